/* File: design/ialu_defs.svh */
// Constants for the integer ALU: widths, register numbers, operand limits
`ifndef IALU_DEFS_SVH
`define IALU_DEFS_SVH

`define IALU_W          32
`define IALU_RIDX_W     4
`define IALU_IMM_W      10
`define IALU_OP_W       18
`define IALU_SP_IDX     4'hD
`define IALU_LR_IDX     4'hE
`define IALU_PC_IDX     4'hF
`define IALU_LOW_MAX    4'h7
`define IALU_IMM3_MAX   10'h007
`define IALU_IMM8_MAX   10'h0FF
`define IALU_SPIMM_MAX  10'h1FC
`define IALU_PCIMM_MAX  10'h3FC
`define IALU_SHR_MIN    10'h001
`define IALU_SHR_MAX    10'h020
`define IALU_SHL_MAX    10'h01F
`define IALU_ASR_CLAMP  8'h21
`define IALU_WIDE_AMT   8'h20
`define IALU_ROT_W      6'h20
`define IALU_ZERO       32'h0000_0000

`endif

/* File: design/ialu_pkg.sv */
// Types shared by the integer ALU and its surroundings
`include "ialu_defs.svh"

package ialu_pkg;

	typedef enum logic [`IALU_OP_W-1:0] {
		op_sum_plain              = 18'h00001,
		op_sum_flagged            = 18'h00002,
		op_sum_with_carry_flagged = 18'h00004,
		op_diff_plain             = 18'h00008,
		op_plain_diff_flagged     = 18'h00010,
		op_difference_with_borrow = 18'h00020,
		op_negate_op              = 18'h00040,
		op_bitwise_conjunction    = 18'h00080,
		op_bitwise_disjunction    = 18'h00100,
		op_bitwise_excl_disj      = 18'h00200,
		op_bit_clear_op           = 18'h00400,
		op_arith_right_shift      = 18'h00800,
		op_logical_left_shift     = 18'h01000,
		op_logical_right_shift    = 18'h02000,
		op_rotate_right           = 18'h04000,
		op_copy_flagged           = 18'h08000,
		op_compare_op             = 18'h10000,
		op_compare_negative       = 18'h20000
	} ialu_op_e;

	typedef struct packed {
		logic                     valid;
		ialu_op_e                 op;
		logic                     use_imm;
		logic                     dst_given;
		logic [`IALU_RIDX_W-1:0]  dst_idx;
		logic [`IALU_RIDX_W-1:0]  src1_idx;
		logic [`IALU_RIDX_W-1:0]  src2_idx;
		logic [`IALU_W-1:0]       src1;
		logic [`IALU_W-1:0]       src2;
		logic [`IALU_IMM_W-1:0]   imm;
	} ialu_req_s;

	typedef struct packed {
		logic                     valid;
		logic                     wr_en;
		logic                     illegal;
		logic [`IALU_RIDX_W-1:0]  dst_idx;
		logic [`IALU_W-1:0]       result;
	} ialu_rsp_s;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} ialu_flags_s;

	typedef struct packed {
		ialu_rsp_s   rsp;
		ialu_flags_s flags;
	} ialu_state_s;

endpackage

/* File: design/ialu_core.sv */
// Integer ALU: add, subtract, logic, shifts, compares and condition flags
`timescale 1ns/1ps
`default_nettype none

module ialu_core
	import ialu_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire ialu_req_s   req,
	output var  ialu_rsp_s   rsp,
	output var  ialu_flags_s flags
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic ialu_low(input logic [`IALU_RIDX_W-1:0] r);
		return r <= `IALU_LOW_MAX;
	endfunction

	function automatic logic ialu_word(input logic [`IALU_IMM_W-1:0] i,
		input logic [`IALU_IMM_W-1:0] lim);
		return (i[1:0] == 2'h0) && (i <= lim);
	endfunction

	// Returns {carry, overflow, sum}
	function automatic logic [`IALU_W+1:0] ialu_addc(
		input logic [`IALU_W-1:0] a,
		input logic [`IALU_W-1:0] b,
		input logic               ci);
		logic [`IALU_W:0] s;
		s = {1'b0, a} + {1'b0, b} + {32'h0000_0000, ci};
		return {s[`IALU_W], (a[31] == b[31]) && (s[31] != a[31]),
			s[`IALU_W-1:0]};
	endfunction

	// Returns {carry, result}
	function automatic logic [`IALU_W:0] ialu_shift(
		input ialu_op_e           op,
		input logic [`IALU_W-1:0] val,
		input logic [7:0]         amt,
		input logic               ci);
		logic [`IALU_W:0]   w;
		logic [`IALU_W-1:0] r;
		logic [7:0]         k;
		w = {ci, val};
		r = val;
		k = (amt > `IALU_ASR_CLAMP) ? `IALU_ASR_CLAMP : amt;
		if (amt != 8'h00) begin
			unique case (op)
			op_logical_left_shift: begin
				w = (amt > `IALU_WIDE_AMT) ? 33'h0_0000_0000
					: {1'b0, val} << amt;
			end
			op_logical_right_shift: begin
				w = {val, 1'b0} >> amt;
				w = {w[0], w[`IALU_W:1]};
			end
			op_arith_right_shift: begin
				w = $signed({val, 1'b0}) >>> k;
				w = {w[0], w[`IALU_W:1]};
			end
			default: begin
				r = (val >> amt[4:0])
					| (val << (`IALU_ROT_W - {1'b0, amt[4:0]}));
				w = {r[31], r};
			end
			endcase
		end
		return w;
	endfunction

	function automatic logic ialu_is_shift(input ialu_op_e op);
		return op inside {op_arith_right_shift, op_logical_left_shift,
			op_logical_right_shift, op_rotate_right};
	endfunction

	function automatic logic ialu_is_logic(input ialu_op_e op);
		return op inside {op_bitwise_conjunction, op_bitwise_disjunction,
			op_bitwise_excl_disj, op_bit_clear_op};
	endfunction

	// ----------------------------------------------------------------
	// Operand checks
	// ----------------------------------------------------------------
	logic [`IALU_RIDX_W-1:0] dst;
	logic [7:0]              amt;
	logic                    req_ok;

	assign dst = req.dst_given ? req.dst_idx : req.src1_idx;
	assign amt = req.use_imm ? req.imm[7:0] : req.src2[7:0];

	always_comb begin
		logic lo2;
		logic lo3;
		lo2 = ialu_low(dst) && ialu_low(req.src1_idx);
		lo3 = lo2 && ialu_low(req.src2_idx);
		req_ok = 1'b0;
		unique case (req.op)
		op_sum_plain: begin
			if (req.use_imm) begin
				req_ok = ((req.src1_idx == `IALU_SP_IDX
					|| req.src1_idx == `IALU_PC_IDX) && ialu_low(dst)
					&& ialu_word(req.imm, `IALU_PCIMM_MAX))
					|| (dst == `IALU_SP_IDX && req.src1_idx == `IALU_SP_IDX
					&& ialu_word(req.imm, `IALU_SPIMM_MAX));
			end else begin
				req_ok = (dst == req.src1_idx)
					&& !(req.src1_idx == `IALU_PC_IDX
					&& req.src2_idx == `IALU_PC_IDX);
			end
		end
		op_diff_plain: begin
			req_ok = req.use_imm && dst == `IALU_SP_IDX
				&& req.src1_idx == `IALU_SP_IDX
				&& ialu_word(req.imm, `IALU_SPIMM_MAX);
		end
		op_sum_flagged, op_plain_diff_flagged: begin
			req_ok = req.use_imm ? lo2 && (req.imm <= `IALU_IMM3_MAX
				|| (dst == req.src1_idx && req.imm <= `IALU_IMM8_MAX))
				: lo3;
		end
		op_sum_with_carry_flagged, op_difference_with_borrow,
		op_bitwise_conjunction, op_bitwise_disjunction,
		op_bitwise_excl_disj, op_bit_clear_op: begin
			req_ok = lo3 && !req.use_imm && dst == req.src1_idx;
		end
		op_negate_op, op_copy_flagged: begin
			req_ok = lo2;
		end
		op_arith_right_shift, op_logical_right_shift: begin
			req_ok = req.use_imm ? lo2 && req.imm >= `IALU_SHR_MIN
				&& req.imm <= `IALU_SHR_MAX
				: lo3 && dst == req.src1_idx;
		end
		op_logical_left_shift: begin
			req_ok = req.use_imm ? lo2 && req.imm <= `IALU_SHL_MAX
				: lo3 && dst == req.src1_idx;
		end
		op_rotate_right: begin
			req_ok = !req.use_imm && lo3 && dst == req.src1_idx;
		end
		op_compare_op: begin
			req_ok = req.src1_idx <= `IALU_LR_IDX && (req.use_imm
				? req.imm <= `IALU_IMM8_MAX : req.src2_idx <= `IALU_LR_IDX);
		end
		op_compare_negative: begin
			req_ok = !req.use_imm && ialu_low(req.src1_idx)
				&& ialu_low(req.src2_idx);
		end
		default: begin
			req_ok = 1'b0;
		end
		endcase
	end

	// ----------------------------------------------------------------
	// Datapath and flag update
	// ----------------------------------------------------------------
	ialu_state_s st;
	ialu_state_s next_st;

	always_comb begin
		logic [`IALU_W-1:0] b;
		logic [`IALU_W+1:0] ar;
		logic [`IALU_W:0]   sh;
		logic [`IALU_W-1:0] res;
		logic               arith;
		b = req.use_imm ? {22'h00_0000, req.imm} : req.src2;
		ar = ialu_addc(req.src1, b, 1'b0);
		sh = ialu_shift(op_logical_left_shift, req.src1, 8'h00, st.flags.c);
		res = ar[`IALU_W-1:0];
		arith = 1'b1;
		next_st = st;
		next_st.rsp = '0;
		unique case (req.op)
		op_sum_with_carry_flagged: begin
			ar = ialu_addc(req.src1, b, st.flags.c);
		end
		op_plain_diff_flagged, op_diff_plain, op_compare_op: begin
			ar = ialu_addc(req.src1, ~b, 1'b1);
		end
		op_difference_with_borrow: begin
			ar = ialu_addc(req.src1, ~b, st.flags.c);
		end
		op_negate_op: begin
			ar = ialu_addc(`IALU_ZERO, ~req.src1, 1'b1);
		end
		op_bitwise_conjunction: begin
			arith = 1'b0;
			res = req.src1 & req.src2;
		end
		op_bitwise_disjunction: begin
			arith = 1'b0;
			res = req.src1 | req.src2;
		end
		op_bitwise_excl_disj: begin
			arith = 1'b0;
			res = req.src1 ^ req.src2;
		end
		op_bit_clear_op: begin
			arith = 1'b0;
			res = req.src1 & ~req.src2;
		end
		op_arith_right_shift, op_logical_left_shift,
		op_logical_right_shift, op_rotate_right: begin
			arith = 1'b0;
			sh = ialu_shift(req.op, req.src1, amt, st.flags.c);
		end
		op_copy_flagged: begin
			arith = 1'b0;
		end
		default: begin
			arith = 1'b1;
		end
		endcase
		if (arith) begin
			res = ar[`IALU_W-1:0];
		end else if (ialu_is_shift(req.op) || req.op == op_copy_flagged) begin
			res = sh[`IALU_W-1:0];
		end
		if (req.valid) begin
			next_st.rsp.valid = 1'b1;
			next_st.rsp.illegal = !req_ok;
			next_st.rsp.dst_idx = dst;
			next_st.rsp.result = res;
			next_st.rsp.wr_en = req_ok && !(req.op inside
				{op_compare_op, op_compare_negative});
			if (req_ok && !(req.op inside {op_sum_plain, op_diff_plain})) begin
				next_st.flags.n = res[31];
				next_st.flags.z = (res == `IALU_ZERO);
				if (arith) begin
					next_st.flags.c = ar[`IALU_W+1];
					next_st.flags.v = ar[`IALU_W];
				end else if (!ialu_is_logic(req.op)) begin
					next_st.flags.c = sh[`IALU_W];
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rsp = st.rsp;
	assign flags = st.flags;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking ck @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_adc_sum;
		req.valid && req_ok && req.op == op_sum_with_carry_flagged
		|=> rsp.result == $past(req.src1) + $past(req.src2)
			+ {31'h0, $past(flags.c)};
	endproperty
	a_adc_sum: assert property (p_adc_sum)
		else $error("adc sum wrong");

	property p_plain_keeps_flags;
		req.valid && req.op inside {op_sum_plain, op_diff_plain}
		|=> $stable(flags) && rsp.valid;
	endproperty
	a_plain_keeps_flags: assert property (p_plain_keeps_flags)
		else $error("plain op changed flags");

	property p_negate;
		req.valid && req_ok && req.op == op_negate_op
		|=> rsp.result == `IALU_ZERO - $past(req.src1)
			&& flags.c == ($past(req.src1) == `IALU_ZERO);
	endproperty
	a_negate: assert property (p_negate)
		else $error("negate wrong");

	property p_sub_carry;
		req.valid && req_ok && !req.use_imm
		&& req.op == op_plain_diff_flagged
		|=> flags.c == ($past(req.src1) >= $past(req.src2))
			&& rsp.wr_en;
	endproperty
	a_sub_carry: assert property (p_sub_carry)
		else $error("sub carry");

	property p_dest_default;
		req.valid && req_ok && !req.dst_given
		|=> rsp.dst_idx == $past(req.src1_idx);
	endproperty
	a_dest_default: assert property (p_dest_default)
		else $error("default destination wrong");

	property p_bic;
		req.valid && req_ok && req.op == op_bit_clear_op
		|=> rsp.result == ($past(req.src1) & ~$past(req.src2));
	endproperty
	a_bic: assert property (p_bic)
		else $error("bit clear wrong");

	property p_logic_cv;
		req.valid && ialu_is_logic(req.op)
		|=> $stable(flags.c) && $stable(flags.v);
	endproperty
	a_logic_cv: assert property (p_logic_cv)
		else $error("logic hit C/V");

	property p_shift_zero;
		req.valid && ialu_is_shift(req.op) && amt == 8'h00
		|=> $stable(flags.c) && $stable(flags.v);
	endproperty
	a_shift_zero: assert property (p_shift_zero)
		else $error("zero shift changed carry");

	property p_compare_no_write;
		req.valid && req.op inside {op_compare_op, op_compare_negative}
		|=> rsp.valid && !rsp.wr_en;
	endproperty
	a_compare_no_write: assert property (p_compare_no_write)
		else $error("compare wrote a register");

	property p_illegal;
		req.valid && !req_ok |=> rsp.illegal && !rsp.wr_en && $stable(flags);
	endproperty
	a_illegal: assert property (p_illegal)
		else $error("illegal took effect");

endmodule

`default_nettype wire

/* File: testbench/ialu_regfile_model.sv */
// Register file and operand fetch standing in front of the integer ALU
`timescale 1ns/1ps
`default_nettype none

module ialu_regfile_model
	import ialu_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire ialu_req_s   cmd,
	input  wire logic        ld_en,
	input  wire logic [3:0]  ld_idx,
	input  wire logic [31:0] ld_val,
	input  wire ialu_rsp_s   rsp,
	output var  ialu_req_s   req
);
	logic [31:0] regs [16];

	// ----------------------------------------------------------------
	// Storage: ALU write-back, then bench preload
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 16; i++) begin
				regs[i] <= 32'h0000_0000;
			end
		end else begin
			if (rsp.valid && rsp.wr_en) begin
				regs[rsp.dst_idx] <= rsp.result;
			end
			if (ld_en) begin
				regs[ld_idx] <= ld_val;
			end
		end
	end

	// ----------------------------------------------------------------
	// Operand read; idle operands show junk, never stale values
	// ----------------------------------------------------------------
	always_comb begin
		req      = cmd;
		req.src1 = regs[cmd.src1_idx];
		req.src2 = regs[cmd.src2_idx];
		if (!cmd.valid) begin
			req.src1 = ~req.src1;
			req.src2 = ~req.src2;
		end
	end
endmodule

`default_nettype wire

/* File: testbench/tb_integer_alu_arith_logic_shift.sv */
// Self-checking bench for the integer ALU
`timescale 1ns/1ps
`default_nettype none

module tb_integer_alu_arith_logic_shift
	import ialu_pkg::*;
;
	typedef struct {
		ialu_op_e    op;
		int          d, s1, s2;
		bit          ui;
		int          imm;
		logic [31:0] v1, v2, res;
		bit          il;
		logic [3:0]  fl;
	} ialu_row_s;

	logic        core_clk = 1'b0;
	logic        reset    = 1'b1;
	ialu_req_s   cmd      = '0;
	ialu_req_s   req;
	ialu_rsp_s   rsp;
	ialu_flags_s flags;
	logic        ld_en    = 1'b0;
	logic [3:0]  ld_idx   = 4'h0;
	logic [31:0] ld_val   = 32'h0;
	int          num_errors = 0;
	int          n_compared = 0;
	ialu_row_s   rows [$];

	always #5 core_clk = ~core_clk;

	ialu_core DUT (.core_clk(core_clk), .reset(reset), .req(req),
		.rsp(rsp), .flags(flags));
	ialu_regfile_model RF (.core_clk(core_clk), .reset(reset),
		.cmd(cmd), .ld_en(ld_en), .ld_idx(ld_idx), .ld_val(ld_val),
		.rsp(rsp), .req(req));

	// ----------------------------------------------------------------
	// Compare, closing and stimulus tasks
	// ----------------------------------------------------------------
	task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_flags(string nm, logic [3:0] e, logic [3:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk_bit(string nm, logic e, logic g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic load(int idx, logic [31:0] val);
		@(negedge core_clk);
		ld_en  = 1'b1;
		ld_idx = idx[3:0];
		ld_val = val;
	endtask

	// Omitted destination whenever it equals the first source
	function automatic ialu_req_s mk(ialu_row_s r);
		ialu_req_s q;
		q           = '0;
		q.valid     = 1'b1;
		q.op        = r.op;
		q.use_imm   = r.ui;
		q.dst_given = (r.d != r.s1);
		q.dst_idx   = r.d[3:0];
		q.src1_idx  = r.s1[3:0];
		q.src2_idx  = r.s2[3:0];
		q.imm       = r.imm[9:0];
		return q;
	endfunction

	task automatic add(ialu_op_e op, int d, int s1, int s2, bit ui,
		int imm, logic [31:0] v1, v2, res, bit il, logic [3:0] fl);
		ialu_row_s r;
		r = '{op, d, s1, s2, ui, imm, v1, v2, res, il, fl};
		rows.push_back(r);
	endtask

	initial begin
		repeat (2000) @(posedge core_clk);
		num_errors++;
		test_done();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		ialu_row_s r;
		logic      wr;
		add(op_sum_flagged, 1, 1, 2, 0, 0, 32'h1, 32'h2, 32'h3, 0, 4'h0);
		add(op_sum_flagged, 3, 1, 2, 1, 7, 32'h1, 32'h0, 32'h8, 0, 4'h0);
		add(op_sum_flagged, 1, 1, 2, 0, 0, 32'hFFFFFFFF, 32'h1, 32'h0, 0, 4'h6);
		add(op_sum_with_carry_flagged, 1, 1, 2, 0, 0, 32'h1, 32'h2, 32'h4, 0, 4'h0);
		add(op_sum_flagged, 1, 1, 2, 0, 0, 32'h7FFFFFFF, 32'h1, 32'h80000000, 0, 4'h9);
		add(op_difference_with_borrow, 1, 1, 2, 0, 0, 32'h5, 32'h3, 32'h1, 0, 4'h2);
		add(op_difference_with_borrow, 1, 1, 2, 0, 0, 32'h5, 32'h3, 32'h2, 0, 4'h2);
		add(op_plain_diff_flagged, 1, 1, 2, 0, 0, 32'h3, 32'h5, 32'hFFFFFFFE, 0, 4'h8);
		add(op_diff_plain, 13, 13, 2, 1, 8, 32'h1000, 32'h0, 32'hFF8, 0, 4'h8);
		add(op_sum_plain, 1, 1, 2, 0, 0, 32'h9, 32'h4, 32'hD, 0, 4'h8);
		add(op_negate_op, 1, 1, 2, 1, 0, 32'h1, 32'h0, 32'hFFFFFFFF, 0, 4'h8);
		add(op_negate_op, 1, 1, 2, 1, 0, 32'h0, 32'h0, 32'h0, 0, 4'h6);
		add(op_compare_negative, 1, 1, 2, 0, 0, 32'h7FFFFFFF, 32'h7FFFFFFF, 32'h0, 0, 4'h9);
		add(op_bitwise_conjunction, 1, 1, 2, 0, 0, 32'hF0F0F0F0, 32'hFF00FF00, 32'hF000F000, 0, 4'h9);
		add(op_bitwise_disjunction, 1, 1, 2, 0, 0, 32'h0F0F0F0F, 32'hF0F0F0F0, 32'hFFFFFFFF, 0, 4'h9);
		add(op_bitwise_excl_disj, 1, 1, 2, 0, 0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 0, 4'h5);
		add(op_bit_clear_op, 1, 1, 2, 0, 0, 32'hFF00FF00, 32'h0F0F0F0F, 32'hF000F000, 0, 4'h9);
		add(op_logical_left_shift, 1, 1, 2, 1, 1, 32'h80000001, 32'h0, 32'h2, 0, 4'h3);
		add(op_logical_right_shift, 1, 1, 2, 1, 32, 32'h80000000, 32'h0, 32'h0, 0, 4'h7);
		add(op_arith_right_shift, 1, 1, 2, 1, 32, 32'h80000000, 32'h0, 32'hFFFFFFFF, 0, 4'hB);
		add(op_rotate_right, 1, 1, 2, 0, 0, 32'h1, 32'h101, 32'h80000000, 0, 4'hB);
		add(op_logical_left_shift, 1, 1, 2, 0, 0, 32'h5, 32'h100, 32'h5, 0, 4'h3);
		add(op_copy_flagged, 1, 1, 2, 1, 0, 32'h0, 32'h0, 32'h0, 0, 4'h7);
		add(op_compare_op, 1, 1, 2, 1, 5, 32'h3, 32'h0, 32'h0, 0, 4'h8);
		add(op_compare_op, 14, 14, 1, 0, 0, 32'h5, 32'h5, 32'h0, 0, 4'h6);
		add(op_sum_plain, 13, 13, 2, 1, 508, 32'h1000, 32'h0, 32'h11FC, 0, 4'h6);
		add(op_plain_diff_flagged, 1, 1, 2, 1, 255, 32'hFF, 32'h0, 32'h0, 0, 4'h6);
		add(op_sum_plain, 2, 15, 1, 1, 1020, 32'h100, 32'h0, 32'h4FC, 0, 4'h6);
		add(op_bitwise_conjunction, 8, 8, 1, 0, 0, 32'h1, 32'h1, 32'h0, 1, 4'h6);
		add(op_sum_flagged, 3, 1, 2, 1, 8, 32'h1, 32'h1, 32'h0, 1, 4'h6);
		add(op_logical_right_shift, 1, 1, 2, 1, 0, 32'h1, 32'h1, 32'h0, 1, 4'h6);
		add(op_sum_plain, 13, 13, 2, 1, 512, 32'h1, 32'h1, 32'h0, 1, 4'h6);
		add(op_sum_plain, 15, 15, 15, 0, 0, 32'h1, 32'h1, 32'h0, 1, 4'h6);
		add(op_diff_plain, 1, 1, 2, 0, 0, 32'h9, 32'h4, 32'h0, 1, 4'h6);
		add(op_compare_op, 15, 15, 1, 0, 0, 32'h1, 32'h1, 32'h0, 1, 4'h6);
		add(op_sum_with_carry_flagged, 2, 1, 3, 0, 0, 32'h1, 32'h1, 32'h0, 1, 4'h6);
		repeat (10) @(negedge core_clk);
		reset = 1'b0;
		chk_flags("flags after reset", 4'h0, flags);
		foreach (rows[i]) begin
			r  = rows[i];
			wr = !r.il && r.op != op_compare_op && r.op != op_compare_negative;
			load(r.s2, r.v2);
			load(r.s1, r.v1);
			@(negedge core_clk);
			ld_en = 1'b0;
			cmd   = mk(r);
			@(negedge core_clk);
			cmd.valid = 1'b0;
			chk_bit("rsp.valid", 1'b1, rsp.valid);
			chk_bit("rsp.illegal", r.il, rsp.illegal);
			chk_bit("rsp.wr_en", wr, rsp.wr_en);
			chk_flags("flags", r.fl, flags);
			if (wr) begin
				chk_word("rsp.result", r.res, rsp.result);
				chk_word("rsp.dst_idx", r.d, 32'(rsp.dst_idx));
			end
		end
		$display("test table done");
		load(1, 32'hFFFFFFFF);
		load(2, 32'h1);
		load(4, 32'h0);
		@(negedge core_clk);
		ld_en = 1'b0;
		cmd   = mk('{op_sum_flagged, 3, 1, 2, 0, 0, 0, 0, 0, 0, 0});
		@(negedge core_clk);
		cmd   = mk('{op_sum_with_carry_flagged, 4, 4, 4, 0, 0, 0, 0, 0, 0, 0});
		chk_word("first result", 32'h0, rsp.result);
		chk_flags("first flags", 4'h6, flags);
		@(negedge core_clk);
		chk_word("chained result", 32'h1, rsp.result);
		chk_flags("chained flags", 4'h0, flags);
		$display("test back_to_back done");
		// Request stands through reset and is taken at the first edge after
		cmd   = mk('{op_sum_flagged, 1, 1, 2, 0, 0, 0, 0, 0, 0, 0});
		reset = 1'b1;
		@(negedge core_clk);
		chk_bit("rsp.valid in reset", 1'b0, rsp.valid);
		chk_flags("flags in reset", 4'h0, flags);
		reset = 1'b0;
		@(negedge core_clk);
		cmd.valid = 1'b0;
		chk_bit("rsp.valid after reset", 1'b1, rsp.valid);
		chk_word("result after reset", 32'h0, rsp.result);
		chk_flags("first flags after reset", 4'h4, flags);
		$display("test reset done");
		test_done();
	end
endmodule

`default_nettype wire
